// file: shared/asw_pkg.sv
package asw_pkg;
    localparam logic [7:0] ADDR_CONFIG = 8'hBC;
    localparam logic [7:0] ADDR_RESULT = 8'hBE;
    localparam logic [7:0] ADDR_UPPER = 8'hC4;
    localparam logic [7:0] ADDR_LOWER = 8'hC6;
    localparam logic [7:0] ADDR_CONTROL = 8'hE8;
    localparam logic [7:0] RESET_CONFIG = 8'hF8;
    localparam logic [7:0] RESET_RESULT = 8'h00;
    localparam logic [7:0] RESET_UPPER = 8'hFF;
    localparam logic [7:0] RESET_LOWER = 8'h00;
    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam int CFG_DIV_LSB = 3;
    localparam int CFG_UNUSED = 2;
    localparam int CTL_ENABLE = 7;
    localparam int CTL_TRACK = 6;
    localparam int CTL_DONE = 5;
    localparam int CTL_BUSY = 4;
    localparam int CTL_SRC_LSB = 1;
    localparam int CTL_WIN = 0;
    localparam logic [2:0] SRC_SOFTWARE = 3'h0;
    localparam logic [2:0] SRC_TIMER3 = 3'h1;
    localparam logic [2:0] SRC_PIN = 3'h2;
    localparam logic [2:0] SRC_TIMER2 = 3'h3;
    localparam logic [3:0] TRACK_SAR_CLOCKS = 4'h3;
    localparam logic [3:0] CONVERT_SAR_CLOCKS = 4'h8;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TRACK = 2'b01,
        ST_CONVERT = 2'b10
    } asw_state_t;
endpackage

// file: shared/asw_sar_if.sv
`timescale 1ns/1ps
interface asw_sar_if;
    logic [4:0] divider;
    logic run;
    logic tick;
    modport ctrl (output divider, output run, input tick);
    modport gen (input divider, input run, output tick);
endinterface

// file: rtl/asw_sar_divider.sv
`timescale 1ns/1ps
module asw_sar_divider (
    input wire ref_clk,
    input wire reset_n,
    asw_sar_if.gen sar
);
    logic [4:0] count;

    // restart on each run so sar periods align to the trigger
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= 5'h00;
            sar.tick <= 1'b0;
        end else if (!sar.run) begin
            count <= 5'h00;
            sar.tick <= 1'b0;
        end else if (count >= sar.divider) begin
            count <= 5'h00;
            sar.tick <= 1'b1; // RULE1
        end else begin
            count <= count + 5'h01;
            sar.tick <= 1'b0;
        end
    end

    chk_tick_period: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE1
        (sar.tick && sar.run && $stable(sar.divider) && sar.divider == 5'h01) |=> !sar.tick)
        else $error("sar tick too frequent");
endmodule

// file: rtl/asw_converter.sv
`timescale 1ns/1ps
// Function
// RULE1: sar clock is system clock divided by divider field plus one
// RULE2: software keeps sar clock at or below 6 MHz
// RULE3: two-bit gain field selects 0.5, 1, 2 or 4
// RULE4: config bit 2 reads zero, writes ignored
// RULE5: enable clear holds converter in shutdown, set allows conversions
// RULE6: normal mode tracks continuously except during conversion
// RULE7: done flag set on busy falling edge, held until software clears
// RULE8: busy reads one only while a conversion runs
// RULE9: writing one to busy starts conversion only with source 000
// RULE10: source 001 timer three, 010 pin rising edge, 011 timer two
// RULE11: source 1xx starts on companion busy write of one
// RULE12: low-power mode tracks three sar clocks after trigger, then converts
// RULE13: low-power pin mode tracks while pin low, converts on rising edge
// RULE14: window flag set on match, held until software clears
// RULE15: every result compared against both limits automatically
// RULE16: inside window when lower limit value exceeds upper limit value
// RULE17: outside window match otherwise
// RULE18: single-ended compare is unsigned
// RULE19: differential compare is two's complement signed
// RULE20: conversion takes at least eight sar clocks after tracking
// RULE21: window compare evaluated with new result when done flag sets
module asw_converter (
    input wire ref_clk,
    input wire reset_n,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire sfr_write,
    input wire sfr_read,
    input wire timer3_overflow,
    input wire timer2_overflow,
    input wire external_start_pin,
    input wire companion_busy_write,
    input wire differential_mode,
    input wire [7:0] conversion_code,
    output logic [7:0] sfr_rdata,
    output logic [1:0] pga_gain_select,
    output logic converter_enable,
    output logic track_active,
    output logic sample_strobe
);
    ///////////////////////////////////////////////////////////////////////
    logic [4:0] sar_clock_divider;
    logic [7:0] sample_result;
    logic [7:0] window_upper_limit;
    logic [7:0] window_lower_limit;
    logic low_power_track_select;
    logic conversion_done_flag;
    logic conversion_busy_bit;
    logic [2:0] start_source_select;
    logic window_match_flag;
    logic pin_prev;
    logic [3:0] sar_count;
    asw_pkg::asw_state_t state;
    asw_pkg::asw_state_t next_state;
    logic trigger;
    logic finish;
    logic match;
    logic wr_config;
    logic wr_result;
    logic wr_upper;
    logic wr_lower;
    logic wr_control;

    asw_sar_if sar ();

    asw_sar_divider u_div (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .sar(sar)
    );

    assign sar.divider = sar_clock_divider;
    assign sar.run = (state != asw_pkg::ST_IDLE);

    assign wr_config = sfr_write && (sfr_addr == asw_pkg::ADDR_CONFIG);
    assign wr_result = sfr_write && (sfr_addr == asw_pkg::ADDR_RESULT);
    assign wr_upper = sfr_write && (sfr_addr == asw_pkg::ADDR_UPPER);
    assign wr_lower = sfr_write && (sfr_addr == asw_pkg::ADDR_LOWER);
    assign wr_control = sfr_write && (sfr_addr == asw_pkg::ADDR_CONTROL);

    // signed compare is just unsigned compare with the sign bits flipped
    function automatic logic greater(input logic [7:0] a, input logic [7:0] b, input logic diff);
        logic [7:0] ax;
        logic [7:0] bx;
        ax = diff ? {~a[7], a[6:0]} : a;
        bx = diff ? {~b[7], b[6:0]} : b;
        return ax > bx;
    endfunction

    ///////////////////////////////////////////////////////////////////////
    // trigger selection
    always_comb begin
        trigger = 1'b0;
        if (converter_enable && state == asw_pkg::ST_IDLE) begin // RULE5
            if (start_source_select[2]) begin
                trigger = companion_busy_write; // RULE11
            end else begin
                case (start_source_select)
                    asw_pkg::SRC_SOFTWARE: trigger = wr_control && sfr_wdata[asw_pkg::CTL_BUSY]; // RULE9
                    asw_pkg::SRC_TIMER3: trigger = timer3_overflow; // RULE10
                    asw_pkg::SRC_PIN: trigger = external_start_pin && !pin_prev; // RULE10 RULE13
                    asw_pkg::SRC_TIMER2: trigger = timer2_overflow; // RULE10
                    default: trigger = 1'b0;
                endcase
            end
        end
    end

    // pin mode in low power already tracked while pin was low
    always_comb begin
        next_state = state;
        case (state)
            asw_pkg::ST_IDLE: begin
                if (trigger) begin
                    if (low_power_track_select && start_source_select != asw_pkg::SRC_PIN) begin
                        next_state = asw_pkg::ST_TRACK; // RULE12
                    end else begin
                        next_state = asw_pkg::ST_CONVERT;
                    end
                end
            end
            asw_pkg::ST_TRACK: begin
                if (sar.tick && sar_count == asw_pkg::TRACK_SAR_CLOCKS - 4'h1) begin
                    next_state = asw_pkg::ST_CONVERT; // RULE12
                end
            end
            asw_pkg::ST_CONVERT: begin
                if (finish) begin
                    next_state = asw_pkg::ST_IDLE;
                end
            end
            default: next_state = asw_pkg::ST_IDLE;
        endcase
        if (!converter_enable) begin
            next_state = asw_pkg::ST_IDLE; // RULE5
        end
    end

    assign finish = (state == asw_pkg::ST_CONVERT) && sar.tick
        && (sar_count == asw_pkg::CONVERT_SAR_CLOCKS - 4'h1); // RULE20

    // compare against the fresh code, not the old stored word
    always_comb begin
        if (greater(window_lower_limit, window_upper_limit, differential_mode)) begin
            match = greater(conversion_code, window_upper_limit, differential_mode)
                && greater(window_lower_limit, conversion_code, differential_mode); // RULE16 RULE18 RULE19
        end else begin
            // outside: below the less-than limit or above the greater-than limit
            match = greater(window_lower_limit, conversion_code, differential_mode)
                || greater(conversion_code, window_upper_limit, differential_mode); // RULE17 RULE18 RULE19
        end
    end

    ///////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= asw_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sar_count <= 4'h0;
        end else if (next_state != state) begin
            sar_count <= 4'h0;
        end else if (sar.tick) begin
            sar_count <= sar_count + 4'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_prev <= 1'b1;
        end else begin
            pin_prev <= external_start_pin;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            conversion_busy_bit <= 1'b0;
        end else begin
            conversion_busy_bit <= (next_state != asw_pkg::ST_IDLE); // RULE8
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sar_clock_divider <= asw_pkg::RESET_CONFIG[7:asw_pkg::CFG_DIV_LSB];
            pga_gain_select <= asw_pkg::RESET_CONFIG[1:0];
        end else if (wr_config) begin
            sar_clock_divider <= sfr_wdata[7:asw_pkg::CFG_DIV_LSB]; // RULE1
            pga_gain_select <= sfr_wdata[1:0]; // RULE3 RULE4
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            window_upper_limit <= asw_pkg::RESET_UPPER;
            window_lower_limit <= asw_pkg::RESET_LOWER;
        end else begin
            if (wr_upper) begin
                window_upper_limit <= sfr_wdata;
            end
            if (wr_lower) begin
                window_lower_limit <= sfr_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sample_result <= asw_pkg::RESET_RESULT;
        end else if (finish) begin
            sample_result <= conversion_code; // RULE15
        end else if (wr_result) begin
            sample_result <= sfr_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            converter_enable <= asw_pkg::RESET_CONTROL[asw_pkg::CTL_ENABLE];
            low_power_track_select <= asw_pkg::RESET_CONTROL[asw_pkg::CTL_TRACK];
            start_source_select <= asw_pkg::RESET_CONTROL[3:1];
        end else if (wr_control) begin
            converter_enable <= sfr_wdata[asw_pkg::CTL_ENABLE]; // RULE5
            low_power_track_select <= sfr_wdata[asw_pkg::CTL_TRACK];
            start_source_select <= sfr_wdata[3:asw_pkg::CTL_SRC_LSB];
        end
    end

    // set wins over a simultaneous software clear
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            conversion_done_flag <= asw_pkg::RESET_CONTROL[asw_pkg::CTL_DONE];
            window_match_flag <= asw_pkg::RESET_CONTROL[asw_pkg::CTL_WIN];
        end else begin
            if (finish) begin
                conversion_done_flag <= 1'b1; // RULE7
            end else if (wr_control) begin
                conversion_done_flag <= sfr_wdata[asw_pkg::CTL_DONE];
            end
            if (finish && match) begin
                window_match_flag <= 1'b1; // RULE14 RULE21
            end else if (wr_control) begin
                window_match_flag <= sfr_wdata[asw_pkg::CTL_WIN];
            end
        end
    end

    ///////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            track_active <= 1'b0;
            sample_strobe <= 1'b0;
        end else begin
            if (!converter_enable) begin
                track_active <= 1'b0;
            end else if (next_state == asw_pkg::ST_CONVERT) begin
                track_active <= 1'b0; // RULE6
            end else if (low_power_track_select) begin
                track_active <= (start_source_select == asw_pkg::SRC_PIN) ? !external_start_pin
                    : (next_state == asw_pkg::ST_TRACK); // RULE12 RULE13
            end else begin
                track_active <= 1'b1; // RULE6
            end
            sample_strobe <= finish;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_read) begin
            case (sfr_addr)
                asw_pkg::ADDR_CONFIG: sfr_rdata <= {sar_clock_divider, 1'b0, pga_gain_select}; // RULE4
                asw_pkg::ADDR_RESULT: sfr_rdata <= sample_result;
                asw_pkg::ADDR_UPPER: sfr_rdata <= window_upper_limit;
                asw_pkg::ADDR_LOWER: sfr_rdata <= window_lower_limit;
                asw_pkg::ADDR_CONTROL: sfr_rdata <= {converter_enable, low_power_track_select,
                    conversion_done_flag, conversion_busy_bit, start_source_select, window_match_flag};
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end

    ///////////////////////////////////////////////////////////////////////
    chk_done_on_fall: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE7
        $fell(conversion_busy_bit) && converter_enable |-> conversion_done_flag)
        else $error("done flag not set on busy fall");

    chk_busy_follows_state: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE8
        (state != asw_pkg::ST_IDLE) |-> conversion_busy_bit)
        else $error("busy low during conversion");

    chk_shutdown_idle: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE5
        !converter_enable |=> state == asw_pkg::ST_IDLE)
        else $error("conversion while disabled");

    chk_sw_start_gate: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE9
        (state == asw_pkg::ST_IDLE && wr_control && sfr_wdata[asw_pkg::CTL_BUSY]
        && start_source_select == asw_pkg::SRC_TIMER3 && !timer3_overflow) |=> state == asw_pkg::ST_IDLE)
        else $error("software start with wrong source");

    // a fast divider already ticks in the first cycle after tracking
    chk_convert_length: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE20
        $rose(state == asw_pkg::ST_CONVERT) |-> !finish [*7])
        else $error("conversion ended too early");

    chk_track_then_convert: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE12
        $rose(state == asw_pkg::ST_TRACK) |-> (state == asw_pkg::ST_TRACK || !converter_enable) [*4])
        else $error("track shorter than three sar clocks");

    chk_window_sets: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE14 RULE21
        finish && match |=> window_match_flag && sample_result == $past(conversion_code))
        else $error("window flag or result missing");

    chk_config_bit2: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE4
        sfr_read && sfr_addr == asw_pkg::ADDR_CONFIG |=> !sfr_rdata[asw_pkg::CFG_UNUSED])
        else $error("config bit 2 not zero");
endmodule

// file: dv/asw_converter_tb.sv
`timescale 1ns/1ps
module asw_converter_tb;
logic ref_clk, reset_n, sfr_write, sfr_read, timer3_overflow, timer2_overflow;
logic external_start_pin, companion_busy_write, differential_mode, rd_q;
logic [7:0] sfr_addr, sfr_wdata, conversion_code, sfr_rdata, cur_up, cur_lo, a, b, c;
logic [1:0] pga_gain_select;
logic converter_enable, track_active, sample_strobe;
logic [7:0] exp_q[$];
logic [31:0] seed;
int mismatches, compares;
asw_converter uut (.ref_clk(ref_clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_write(sfr_write), .sfr_read(sfr_read), .timer3_overflow(timer3_overflow),
    .timer2_overflow(timer2_overflow), .external_start_pin(external_start_pin),
    .companion_busy_write(companion_busy_write), .differential_mode(differential_mode),
    .conversion_code(conversion_code), .sfr_rdata(sfr_rdata), .pga_gain_select(pga_gain_select),
    .converter_enable(converter_enable), .track_active(track_active), .sample_strobe(sample_strobe));
initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
end
////////////////////////////////////////////////////////////////////////////////
function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction
// limits and code compared signed in differential mode, unsigned otherwise
function automatic logic win_exp(logic [7:0] cd, logic [7:0] up, logic [7:0] lo, logic df);
    logic signed [8:0] cs, us, ls;
    cs = df ? {cd[7], cd} : {1'b0, cd};
    us = df ? {up[7], up} : {1'b0, up};
    ls = df ? {lo[7], lo} : {1'b0, lo};
    if (ls > us) return (cs > us) && (cs < ls);
    return (cs < ls) || (cs > us);
endfunction
task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
        mismatches++;
        $display("Error %s expected %h seen %h", what, exp, seen);
    end
endtask
task automatic finish_test();
    // let the monitor take the last queued read first
    repeat (2) @(posedge ref_clk);
    if (exp_q.size() != 0) begin
        mismatches++;
        $display("Error exp_q expected 0 seen %0d", exp_q.size());
    end
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
        $display("ALL CHECKS OK");
    end else begin
        $display("CHECKS NOT OK");
    end
    $finish;
endtask
task automatic wr(logic [7:0] ad, logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = ad;
    sfr_wdata = d;
    sfr_write = 1'b1;
    @(negedge ref_clk);
    sfr_write = 1'b0;
endtask
task automatic rd(logic [7:0] ad, logic [7:0] exp);
    @(negedge ref_clk);
    sfr_addr = ad;
    sfr_read = 1'b1;
    exp_q.push_back(exp);
    @(negedge ref_clk);
    sfr_read = 1'b0;
endtask
// read data lands one edge after the strobe edge
always @(posedge ref_clk) rd_q <= sfr_read;
always @(negedge ref_clk) begin
    if (rd_q === 1'b1) begin
        if (exp_q.size() == 0) begin
            mismatches++;
            $display("Error sfr_rdata expected queued value seen %h", sfr_rdata);
        end else begin
            check("sfr_rdata", sfr_rdata, exp_q.pop_front());
        end
    end
end
////////////////////////////////////////////////////////////////////////////////
task automatic fire(int s, logic [7:0] ctl);
    if (s == 0) begin
        wr(8'hE8, ctl | 8'h10);
    end else begin
        @(negedge ref_clk);
        timer3_overflow = (s == 1);
        timer2_overflow = (s == 3);
        companion_busy_write = (s == 4);
        if (s == 2) external_start_pin = 1'b1;
        @(negedge ref_clk);
        timer3_overflow = 1'b0;
        timer2_overflow = 1'b0;
        companion_busy_write = 1'b0;
    end
endtask
task automatic convert(logic [2:0] src, logic lp, logic [4:0] d, logic [7:0] cd, logic df);
    logic [7:0] ctl;
    int n, k, lim, nt, lo, hi;
    k = (src >= 3'h4) ? 4 : src;
    ctl = {1'b1, lp, 2'b00, src, 1'b0};
    lim = 12 * (d + 1) + 40;
    nt = (lp && k != 2) ? 11 : 8;
    wr(8'hBC, {d, 1'b0, 2'(rnd())});
    wr(8'hE8, ctl);
    conversion_code = cd;
    differential_mode = df;
    for (int j = 0; j < 5; j++) if (j != k) fire(j, ctl);
    repeat (lim) @(negedge ref_clk);
    external_start_pin = 1'b0;
    rd(8'hE8, ctl);
    if (k == 2 && lp) check("track_active", {7'h00, track_active}, 8'h01);
    fire(k, ctl);
    if (!lp) begin
        rd(8'hE8, ctl | 8'h10);
        check("track_active", {7'h00, track_active}, 8'h00);
    end
    n = 0;
    while (sample_strobe !== 1'b1 && n < lim) begin
        @(posedge ref_clk);
        #1;
        n++;
    end
    if (n >= lim) begin
        mismatches++;
        finish_test();
    end
    lo = nt * (d + 1) - d - 6;
    hi = nt * (d + 1) + d + 4;
    check("conv_cycles", {7'h00, (n >= lo && n <= hi)}, 8'h01);
    @(negedge ref_clk);
    external_start_pin = 1'b0;
    rd(8'hBE, cd);
    rd(8'hE8, ctl | 8'h20 | {7'h00, win_exp(cd, cur_up, cur_lo, df)});
    repeat (5) @(negedge ref_clk);
    rd(8'hE8, ctl | 8'h20 | {7'h00, win_exp(cd, cur_up, cur_lo, df)});
    check("track_idle", {7'h00, track_active}, {7'h00, (!lp || k == 2)});
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    {sfr_write, sfr_read, timer3_overflow, timer2_overflow} = 4'h0;
    {external_start_pin, companion_busy_write, differential_mode} = 3'h0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    conversion_code = 8'h00;
    cur_up = 8'hFF;
    cur_lo = 8'h00;
    seed = 32'h0000001B;
    reset_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    rd(8'hBC, 8'hF8);
    rd(8'hBE, 8'h00);
    rd(8'hC4, 8'hFF);
    rd(8'hC6, 8'h00);
    rd(8'hE8, 8'h00);
    check("gain", {6'h00, pga_gain_select}, 8'h00);
    for (int g = 0; g < 4; g++) begin
        wr(8'hBC, {5'h1F, 1'b1, g[1:0]});
        rd(8'hBC, {5'h1F, 1'b0, g[1:0]});
        check("gain", {6'h00, pga_gain_select}, {6'h00, g[1:0]});
    end
    wr(8'hBE, 8'h5A);
    rd(8'hBE, 8'h5A);
    wr(8'hBD, 8'hFF);
    rd(8'hBD, 8'h00);
    $display("test registers done");
    // disabled converter ignores a start
    wr(8'hE8, 8'h10);
    repeat (300) @(negedge ref_clk);
    rd(8'hE8, 8'h00);
    check("enable", {7'h00, converter_enable}, 8'h00);
    check("track_off", {7'h00, track_active}, 8'h00);
    $display("test shutdown done");
    // at 250 MHz even the slowest divider exceeds the sar clock ceiling
    for (int i = 0; i < 12; i++) begin
        a = 8'(rnd());
        c = (i % 6 == 5) ? 8'h07 : (i % 6 == 4) ? 8'h04 : 8'(i % 6);
        convert(c[2:0], (i >= 6), (i % 3 == 0) ? 5'h00 : (i % 3 == 1) ? 5'h05 : 5'h1F, a, 1'b0);
    end
    $display("test sources done");
    for (int i = 0; i < 16; i++) begin
        cur_up = 8'(rnd());
        cur_lo = 8'(rnd());
        a = 8'(rnd());
        b = a % 5;
        c = (b == 0) ? cur_up : (b == 1) ? cur_up + 8'h01 : (b == 2) ? cur_lo : (b == 3) ? cur_lo - 8'h01 : a;
        wr(8'hC4, cur_up);
        wr(8'hC6, cur_lo);
        rd(8'hC4, cur_up);
        rd(8'hC6, cur_lo);
        convert(3'h0, 1'b0, 5'h00, c, a[7]);
    end
    $display("test window done");
    finish_test();
end
endmodule
